// [include/dgcs_defs.vh]
// Constants of the global DMA control and status block.
// Assumes byte addressing on a 32-bit AXI4-Lite register bus.
`ifndef DGCS_DEFS_VH
`define DGCS_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte addresses
`define DGCS_ADDR_W 16
`define DGCS_CTRL_ADDR 16'h3000
`define DGCS_STAT_ADDR 16'h3010
`define DGCS_DST_PTR_ADDR 16'h3320
`define DGCS_CELL_PTR_ADDR 16'h3340
`define DGCS_PATTERN_ADDR 16'h3350

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define DGCS_ENABLE_BIT 15
`define DGCS_SUSPEND_BIT 12
`define DGCS_ACTIVE_BIT 11
`define DGCS_DIR_BIT 3
`define DGCS_CHAN_MSB 2
`define DGCS_CHAN_LSB 0
`define DGCS_PTR_MSB 15
`define DGCS_PAT_MSB 7
`define DGCS_CTRL_LANE 1
`define DGCS_PAT_LANE 0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define DGCS_PTR_RESET 16'h0000
`define DGCS_PAT_RESET 8'h00
`define DGCS_CHAN_RESET 3'h0
`define DGCS_WORD_ZERO 32'h00000000

////////////////////////////////////////////////////////////////////////////////
// Bus responses
`define DGCS_RESP_OKAY 2'h0
`define DGCS_RESP_SLVERR 2'h2

////////////////////////////////////////////////////////////////////////////////
// Engine states
`define DGCS_ST_OFF 2'h0
`define DGCS_ST_RUN 2'h1
`define DGCS_ST_HOLD 2'h2

`endif

// [hdl/dgcs_axil_slave.v]
// AXI4-Lite slave front end: turns bus transfers into register strobes.
// Assumes the owner decodes addresses combinationally on the same clock.
`timescale 1ns/10ps
`include "dgcs_defs.vh"

module dgcs_axil_slave #(
   parameter ADDR_W = `DGCS_ADDR_W
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Write address and data
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // Write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // Read address and data
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Register strobes
   output wire regWrite,
   output wire [ADDR_W-1:0] regWriteAddr,
   output wire [31:0] regWriteData,
   output wire [3:0] regWriteStrb,
   input wire regWriteOk,
   output wire [ADDR_W-1:0] regReadAddr,
   input wire [31:0] regReadData,
   input wire regReadOk
);

   reg awHeld_reg;
   reg wHeld_reg;
   reg [ADDR_W-1:0] awAddr_reg;
   reg [31:0] wData_reg;
   reg [3:0] wStrb_reg;
   wire readTake;

   ////////////////////////////////////////////////////////////////////////////////
   // Write path
   assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
   assign regWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   assign regWriteAddr = awAddr_reg;
   assign regWriteData = wData_reg;
   assign regWriteStrb = wStrb_reg;

   always @(posedge clk_sys) begin
      if (rst) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= {ADDR_W{1'b0}};
         wData_reg <= `DGCS_WORD_ZERO;
         wStrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DGCS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (regWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= regWriteOk ? `DGCS_RESP_OKAY : `DGCS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: data sampled at the address handshake
   assign s_axi_arready = !s_axi_rvalid;
   assign readTake = s_axi_arvalid && s_axi_arready;
   assign regReadAddr = s_axi_araddr;

   always @(posedge clk_sys) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `DGCS_WORD_ZERO;
         s_axi_rresp <= `DGCS_RESP_OKAY;
      end else if (readTake) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= regReadOk ? regReadData : `DGCS_WORD_ZERO;
         s_axi_rresp <= regReadOk ? `DGCS_RESP_OKAY : `DGCS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // dgcs_axil_slave

// [hdl/dgcs_top.v]
// Global control and status of a multi-channel DMA controller, with the
// channel 3 pointer and pattern registers, behind an AXI4-Lite slave.
// Assumes the channel engines run on clk_sys and report accesses in step.
`timescale 1ns/10ps
`include "dgcs_defs.vh"

module dgcs_top #(
   parameter ADDR_W = `DGCS_ADDR_W,
   parameter CHAN_W = 3,
   parameter PTR_W = 16,
   parameter PAT_W = 8
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // AXI4-Lite write address and data
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // Channel engine activity
   input wire engineBusy,
   input wire busAccess,
   input wire busAccessRead,
   input wire [CHAN_W-1:0] busAccessChannel,
   // Channel 3 progress from its engine
   input wire ptrUpdate,
   input wire [PTR_W-1:0] destinationProgressPointer,
   input wire [PTR_W-1:0] cellProgressPointer,
   // Global controls to the channel engines
   output reg moduleEnable,
   output reg transferGrant,
   output wire [PAT_W-1:0] matchPatternValue
);

   // Register state
   reg enable_reg;
   reg suspend_reg;
   reg lastDirRead_reg;
   reg [CHAN_W-1:0] lastChannel_reg;
   reg [PTR_W-1:0] dstPtr_reg;
   reg [PTR_W-1:0] cellPtr_reg;
   reg [PAT_W-1:0] pattern_reg;
   reg [1:0] state_reg;
   reg [1:0] state_next;

   // Engine gate states
   localparam [1:0] ST_OFF = `DGCS_ST_OFF;
   localparam [1:0] ST_RUN = `DGCS_ST_RUN;
   localparam [1:0] ST_HOLD = `DGCS_ST_HOLD;

   // Bus strobes
   wire regWrite;
   wire [ADDR_W-1:0] regWriteAddr;
   wire [31:0] regWriteData;
   wire [3:0] regWriteStrb;
   wire [ADDR_W-1:0] regReadAddr;
   reg [31:0] regReadData;
   wire regWriteOk;
   wire regReadOk;
   wire moduleActive;
   wire ctrlWrite;
   wire patWrite;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode, shared by the read and write paths
   function isMapped;
      input [ADDR_W-1:0] addr;
      begin
         isMapped = (addr == `DGCS_CTRL_ADDR) || (addr == `DGCS_STAT_ADDR) ||
                    (addr == `DGCS_DST_PTR_ADDR) || (addr == `DGCS_CELL_PTR_ADDR) ||
                    (addr == `DGCS_PATTERN_ADDR);
      end
   endfunction

   // Zero-extend a narrow field to a bus word
   function [31:0] zeroExtend16;
      input [15:0] value;
      begin
         zeroExtend16 = {16'h0000, value};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus front end
   dgcs_axil_slave #(
      .ADDR_W(ADDR_W)
   ) u_slave (
      .clk_sys(clk_sys),
      .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .regWrite(regWrite),
      .regWriteAddr(regWriteAddr),
      .regWriteData(regWriteData),
      .regWriteStrb(regWriteStrb),
      .regWriteOk(regWriteOk),
      .regReadAddr(regReadAddr),
      .regReadData(regReadData),
      .regReadOk(regReadOk)
   );

   assign regWriteOk = isMapped(regWriteAddr);
   assign regReadOk = isMapped(regReadAddr);

   // Only the lanes that hold a writable field take effect
   assign ctrlWrite = regWrite && (regWriteAddr == `DGCS_CTRL_ADDR) &&
                      regWriteStrb[`DGCS_CTRL_LANE];
   assign patWrite = regWrite && (regWriteAddr == `DGCS_PATTERN_ADDR) &&
                     regWriteStrb[`DGCS_PAT_LANE];

   ////////////////////////////////////////////////////////////////////////////////
   // Control register: enable and suspend
   always @(posedge clk_sys) begin
      if (rst) begin
         enable_reg <= 1'b0;
         suspend_reg <= 1'b0;
      end else if (ctrlWrite) begin
         enable_reg <= regWriteData[`DGCS_ENABLE_BIT];
         suspend_reg <= regWriteData[`DGCS_SUSPEND_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Engine gate: off, running, or held for the CPU
   always @* begin
      case (state_reg)
         ST_OFF: begin
            if (enable_reg && suspend_reg) begin
               state_next = ST_HOLD;
            end else if (enable_reg) begin
               state_next = ST_RUN;
            end else begin
               state_next = ST_OFF;
            end
         end
         ST_RUN: begin
            if (!enable_reg) begin
               state_next = ST_OFF;
            end else if (suspend_reg) begin
               state_next = ST_HOLD;
            end else begin
               state_next = ST_RUN;
            end
         end
         ST_HOLD: begin
            if (!enable_reg) begin
               state_next = ST_OFF;
            end else if (!suspend_reg) begin
               state_next = ST_RUN;
            end else begin
               state_next = ST_HOLD;
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= ST_OFF;
         moduleEnable <= 1'b0;
         transferGrant <= 1'b0;
      end else begin
         state_reg <= state_next;
         moduleEnable <= (state_next != ST_OFF);
         transferGrant <= (state_next == ST_RUN);
      end
   end

   // Active while enabled, or while an engine still finishes a transfer
   assign moduleActive = moduleEnable || engineBusy;

   ////////////////////////////////////////////////////////////////////////////////
   // Status: direction and channel of the latest bus access
   always @(posedge clk_sys) begin
      if (rst) begin
         lastDirRead_reg <= 1'b0;
         lastChannel_reg <= `DGCS_CHAN_RESET;
      end else if (busAccess) begin
         lastDirRead_reg <= busAccessRead;
         lastChannel_reg <= busAccessChannel;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Channel 3 pointers and pattern
   always @(posedge clk_sys) begin
      if (rst) begin
         dstPtr_reg <= `DGCS_PTR_RESET;
         cellPtr_reg <= `DGCS_PTR_RESET;
      end else if (ptrUpdate) begin
         dstPtr_reg <= destinationProgressPointer;
         cellPtr_reg <= cellProgressPointer;
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         pattern_reg <= `DGCS_PAT_RESET;
      end else if (patWrite) begin
         pattern_reg <= regWriteData[`DGCS_PAT_MSB:0];
      end
   end

   assign matchPatternValue = pattern_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux; every bit not named below reads as zero
   always @* begin
      regReadData = `DGCS_WORD_ZERO;
      case (regReadAddr)
         `DGCS_CTRL_ADDR: begin
            regReadData[`DGCS_ENABLE_BIT] = enable_reg;
            regReadData[`DGCS_SUSPEND_BIT] = suspend_reg;
            regReadData[`DGCS_ACTIVE_BIT] = moduleActive;
         end
         `DGCS_STAT_ADDR: begin
            regReadData[`DGCS_DIR_BIT] = lastDirRead_reg;
            regReadData[`DGCS_CHAN_MSB:`DGCS_CHAN_LSB] = lastChannel_reg;
         end
         `DGCS_DST_PTR_ADDR: begin
            regReadData = zeroExtend16(dstPtr_reg);
         end
         `DGCS_CELL_PTR_ADDR: begin
            regReadData = zeroExtend16(cellPtr_reg);
         end
         `DGCS_PATTERN_ADDR: begin
            regReadData[`DGCS_PAT_MSB:0] = pattern_reg;
         end
         default: begin
            regReadData = `DGCS_WORD_ZERO;
         end
      endcase
   end

endmodule // dgcs_top

// [test/dgcs_top_chk.sv]
// Checker for the global control block, bound to its top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`include "dgcs_defs.vh"
module dgcs_top_chk (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Register bus
   input wire [15:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire [15:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   // Global controls
   input wire moduleEnable,
   input wire transferGrant,
   input wire [7:0] matchPatternValue
);
////////////////////////////////////////
wire wrHs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
wire rdHs = s_axi_arvalid && s_axi_arready;
wire ctrlWr = wrHs && s_axi_awaddr == `DGCS_CTRL_ADDR && s_axi_wstrb[1];
wire rdMapped = s_axi_araddr inside {`DGCS_CTRL_ADDR, `DGCS_STAT_ADDR, `DGCS_DST_PTR_ADDR,
   `DGCS_CELL_PTR_ADDR, `DGCS_PATTERN_ADDR};
default clocking cb @(posedge clk_sys); endclocking
default disable iff (rst);
a_enable_follows: assert property (ctrlWr |-> ##3 moduleEnable == $past(s_axi_wdata[15], 3))
   else $error("enable output does not follow control write");
a_grant_suspend: assert property (ctrlWr |-> ##3 transferGrant ==
   ($past(s_axi_wdata[15], 3) && !$past(s_axi_wdata[12], 3)))
   else $error("grant does not follow enable and suspend");
a_grant_enable: assert property (transferGrant |-> moduleEnable)
   else $error("grant while disabled");
a_ctrl_unused: assert property (rdHs && s_axi_araddr == `DGCS_CTRL_ADDR |->
   ##[1:2] s_axi_rvalid && (s_axi_rdata & 32'hFFFF67FF) == 32'h00000000)
   else $error("control unused bits not zero");
a_stat_unused: assert property (rdHs && s_axi_araddr == `DGCS_STAT_ADDR |->
   ##[1:2] s_axi_rvalid && s_axi_rdata[31:4] == 28'h0000000)
   else $error("status unused bits not zero");
a_pat_read: assert property (rdHs && s_axi_araddr == `DGCS_PATTERN_ADDR |->
   ##[1:2] s_axi_rvalid && s_axi_rdata == {24'h000000, matchPatternValue})
   else $error("pattern read differs from pattern output");
a_pat_write: assert property (wrHs && s_axi_awaddr == `DGCS_PATTERN_ADDR && s_axi_wstrb[0] |->
   ##3 matchPatternValue == $past(s_axi_wdata[7:0], 3))
   else $error("pattern write not applied");
a_unmapped_rd: assert property (rdHs && !rdMapped |->
   ##[1:2] s_axi_rvalid && s_axi_rresp == `DGCS_RESP_SLVERR && s_axi_rdata == 32'h00000000)
   else $error("unmapped read not refused");
a_write_answer: assert property (wrHs |-> ##[1:2] s_axi_bvalid)
   else $error("write response missing");
cover property (ctrlWr);
cover property (rdHs && s_axi_araddr == `DGCS_STAT_ADDR);
cover property (s_axi_bvalid && s_axi_bresp == `DGCS_RESP_SLVERR);
endmodule // dgcs_top_chk

bind dgcs_top dgcs_top_chk u_chk (
   .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .moduleEnable(moduleEnable), .transferGrant(transferGrant),
   .matchPatternValue(matchPatternValue)
);

// [test/dgcs_engine_model.sv]
// Channel engine stand-in: makes bus accesses only while granted.
// Assumes the bench pulses req for one clock per access.
`timescale 1ns/10ps
module dgcs_engine_model (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Requests from the bench
   input wire req,
   input wire reqRead,
   input wire [2:0] reqChan,
   input wire [15:0] ptrVal,
   input wire transferGrant,
   // Engine activity
   output reg engineBusy = 1'b0,
   output reg busAccess = 1'b0,
   output reg busAccessRead = 1'b0,
   output reg [2:0] busAccessChannel = 3'h0,
   output reg ptrUpdate = 1'b0,
   output reg [15:0] dstPtr = 16'h0000,
   output reg [15:0] cellPtr = 16'h0000
);
reg pending_reg = 1'b0;
reg pendRead_reg = 1'b0;
reg [2:0] pendChan_reg = 3'h0;
reg [15:0] pendPtr_reg = 16'h0000;
////////////////////////////////////////
always @(posedge clk_sys) begin
   busAccess <= 1'b0;
   ptrUpdate <= 1'b0;
   // Qualifiers are meaningless outside an access, so keep them moving
   busAccessRead <= ~busAccessRead;
   busAccessChannel <= ~busAccessChannel;
   dstPtr <= ~dstPtr;
   cellPtr <= ~cellPtr;
   engineBusy <= pending_reg || req;
   if (req) begin
      pending_reg <= 1'b1;
      pendRead_reg <= reqRead;
      pendChan_reg <= reqChan;
      pendPtr_reg <= ptrVal;
   end else if (pending_reg && transferGrant) begin
      pending_reg <= 1'b0;
      busAccess <= 1'b1;
      busAccessRead <= pendRead_reg;
      busAccessChannel <= pendChan_reg;
      ptrUpdate <= 1'b1;
      dstPtr <= pendPtr_reg;
      cellPtr <= ~pendPtr_reg;
   end
   if (rst) begin
      pending_reg <= 1'b0;
      engineBusy <= 1'b0;
      busAccess <= 1'b0;
      ptrUpdate <= 1'b0;
   end
end
endmodule // dgcs_engine_model

// [test/dgcs_top_bench.sv]
// Bench for the global control block: bus tasks and directed tests.
// Assumes the engine model stands in for the channel engines.
`timescale 1ns/10ps
`include "dgcs_defs.vh"
module dgcs_top_bench;
reg clk_sys = 1'b0;
reg rst = 1'b1;
reg [15:0] s_axi_awaddr = 16'h0000;
reg s_axi_awvalid = 1'b0;
reg [31:0] s_axi_wdata = 32'h00000000;
reg [3:0] s_axi_wstrb = 4'h0;
reg s_axi_wvalid = 1'b0;
reg s_axi_bready = 1'b0;
reg [15:0] s_axi_araddr = 16'h0000;
reg s_axi_arvalid = 1'b0;
reg s_axi_rready = 1'b0;
reg req = 1'b0;
reg reqRead = 1'b0;
reg [2:0] reqChan = 3'h0;
reg [15:0] ptrVal = 16'h0000;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
wire engineBusy, busAccess, busAccessRead, ptrUpdate, moduleEnable, transferGrant;
wire [2:0] busAccessChannel;
wire [15:0] dstPtr, cellPtr;
wire [7:0] matchPatternValue;
integer fails = 0;
integer cmpCount = 0;
integer c;
////////////////////////////////////////
dgcs_top DUT (
   .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .engineBusy(engineBusy), .busAccess(busAccess), .busAccessRead(busAccessRead),
   .busAccessChannel(busAccessChannel), .ptrUpdate(ptrUpdate), .destinationProgressPointer(dstPtr),
   .cellProgressPointer(cellPtr), .moduleEnable(moduleEnable), .transferGrant(transferGrant),
   .matchPatternValue(matchPatternValue)
);
dgcs_engine_model u_eng (
   .clk_sys(clk_sys), .rst(rst), .req(req), .reqRead(reqRead), .reqChan(reqChan), .ptrVal(ptrVal),
   .transferGrant(transferGrant), .engineBusy(engineBusy), .busAccess(busAccess),
   .busAccessRead(busAccessRead), .busAccessChannel(busAccessChannel), .ptrUpdate(ptrUpdate),
   .dstPtr(dstPtr), .cellPtr(cellPtr)
);
initial begin
   forever #10 clk_sys = ~clk_sys;
end
////////////////////////////////////////
task check(input [31:0] got, input [31:0] exp);
   begin
      cmpCount = cmpCount + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("MISMATCH at %0t: seen %h expected %h", $time, got, exp);
      end
   end
endtask
task give_verdict;
   begin
      if (fails == 0 && cmpCount > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
endtask
task axiWrite(input [15:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
   reg awDone;
   reg wDone;
   begin
      awDone = 1'b0;
      wDone = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // Each half is released at the edge that takes it
      while (!(awDone && wDone)) begin
         @(posedge clk_sys);
         if (s_axi_awready && !awDone) begin
            awDone = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !wDone) begin
            wDone = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk_sys); while (!s_axi_bvalid);
      check(s_axi_bresp, r);
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   end
endtask
task axiRead(input [15:0] a, input [31:0] d, input [1:0] r);
   begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      check(s_axi_rdata, d);
      check(s_axi_rresp, r);
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   end
endtask
task access(input rd, input [2:0] ch, input [15:0] p);
   begin
      req <= 1'b1;
      reqRead <= rd;
      reqChan <= ch;
      ptrVal <= p;
      @(posedge clk_sys);
      req <= 1'b0;
      repeat (4) @(posedge clk_sys);
   end
endtask
////////////////////////////////////////
initial begin
   repeat (10) @(posedge clk_sys);
   rst <= 1'b0;
   @(posedge clk_sys);
   axiRead(`DGCS_CTRL_ADDR, 32'h00000000, `DGCS_RESP_OKAY);
   axiRead(`DGCS_STAT_ADDR, 32'h00000000, `DGCS_RESP_OKAY);
   axiRead(`DGCS_DST_PTR_ADDR, 32'h00000000, `DGCS_RESP_OKAY);
   axiRead(`DGCS_CELL_PTR_ADDR, 32'h00000000, `DGCS_RESP_OKAY);
   axiRead(`DGCS_PATTERN_ADDR, 32'h00000000, `DGCS_RESP_OKAY);
   // Access stays pending while disabled, yet the engine is busy
   access(1'b1, 3'h5, 16'h1234);
   axiRead(`DGCS_CTRL_ADDR, 32'h00000800, `DGCS_RESP_OKAY);
   axiRead(`DGCS_STAT_ADDR, 32'h00000000, `DGCS_RESP_OKAY);
   axiWrite(`DGCS_CTRL_ADDR, 32'hFFFFFFFF, 4'hF, `DGCS_RESP_OKAY);
   check(moduleEnable, 1'b1);
   check(transferGrant, 1'b0);
   axiRead(`DGCS_CTRL_ADDR, 32'h00009800, `DGCS_RESP_OKAY);
   axiRead(`DGCS_STAT_ADDR, 32'h00000000, `DGCS_RESP_OKAY);
   axiWrite(`DGCS_CTRL_ADDR, 32'h00008000, 4'h2, `DGCS_RESP_OKAY);
   repeat (3) @(posedge clk_sys);
   axiRead(`DGCS_STAT_ADDR, 32'h0000000D, `DGCS_RESP_OKAY);
   axiRead(`DGCS_DST_PTR_ADDR, 32'h00001234, `DGCS_RESP_OKAY);
   axiRead(`DGCS_CELL_PTR_ADDR, 32'h0000EDCB, `DGCS_RESP_OKAY);
   for (c = 0; c < 8; c = c + 1) begin
      access(~c[0], c[2:0], 16'hA000);
      axiRead(`DGCS_STAT_ADDR, {28'h0000000, ~c[0], c[2:0]}, `DGCS_RESP_OKAY);
   end
   axiWrite(`DGCS_STAT_ADDR, 32'hFFFFFFFF, 4'hF, `DGCS_RESP_OKAY);
   axiRead(`DGCS_STAT_ADDR, 32'h00000007, `DGCS_RESP_OKAY);
   axiWrite(`DGCS_PATTERN_ADDR, 32'hFFFFFFA5, 4'hF, `DGCS_RESP_OKAY);
   axiRead(`DGCS_PATTERN_ADDR, 32'h000000A5, `DGCS_RESP_OKAY);
   check(matchPatternValue, 8'hA5);
   axiWrite(`DGCS_PATTERN_ADDR, 32'h0000005A, 4'hE, `DGCS_RESP_OKAY);
   axiRead(`DGCS_PATTERN_ADDR, 32'h000000A5, `DGCS_RESP_OKAY);
   axiWrite(16'h3004, 32'hFFFFFFFF, 4'hF, `DGCS_RESP_SLVERR);
   axiRead(16'h3004, 32'h00000000, `DGCS_RESP_SLVERR);
   axiWrite(`DGCS_CTRL_ADDR, 32'h00000000, 4'hD, `DGCS_RESP_OKAY);
   axiRead(`DGCS_CTRL_ADDR, 32'h00008800, `DGCS_RESP_OKAY);
   // Suspend while running holds a new access until resumed
   axiWrite(`DGCS_CTRL_ADDR, 32'h00009000, 4'h2, `DGCS_RESP_OKAY);
   check(transferGrant, 1'b0);
   access(1'b0, 3'h3, 16'h0055);
   axiRead(`DGCS_STAT_ADDR, 32'h00000007, `DGCS_RESP_OKAY);
   axiWrite(`DGCS_CTRL_ADDR, 32'h00008000, 4'h2, `DGCS_RESP_OKAY);
   repeat (3) @(posedge clk_sys);
   axiRead(`DGCS_STAT_ADDR, 32'h00000003, `DGCS_RESP_OKAY);
   axiRead(`DGCS_DST_PTR_ADDR, 32'h00000055, `DGCS_RESP_OKAY);
   axiWrite(`DGCS_CTRL_ADDR, 32'h00000000, 4'hF, `DGCS_RESP_OKAY);
   // Pause after disabling before touching registers again
   repeat (2) @(posedge clk_sys);
   axiRead(`DGCS_CTRL_ADDR, 32'h00000000, `DGCS_RESP_OKAY);
   check(moduleEnable, 1'b0);
   give_verdict;
end
initial begin
   repeat (5000) @(posedge clk_sys);
   fails = fails + 1;
   give_verdict;
end
endmodule // dgcs_top_bench
